// *** include/record_framer_defines.svh ***
/*
 * constants of the binary record framer: header codes, common section
 * layout, register offsets, field positions and reset values.
 * assumes it is included by bare name from every file that needs it.
 */
`ifndef RECORD_FRAMER_DEFINES_SVH
`define RECORD_FRAMER_DEFINES_SVH

// ****************************************
// header codes
// ****************************************
`define SYNC_BYTE      8'hA5
`define HDR_LEN_SHORT  8'h0A
`define HDR_LEN_LONG   8'h0C
`define HDR_SIZE_POS   16'h0004
`define TYPE_AVERAGE   8'h16
`define TYPE_ALTIMETER 8'h21
`define TYPE_BOTTOM    8'h1B
`define TYPE_WATER     8'h1D
`define TYPE_STRING    8'hA0
`define VER_PROFILE    8'h03
`define VER_BOTTOM     8'h14
`define COMMON_LEN     16'h0012

// ****************************************
// register byte offsets
// ****************************************
`define REG_CTRL    8'h00
`define REG_CMD     8'h04
`define REG_FAMILY  8'h08
`define REG_SERIAL  8'h0C
`define REG_DATE    8'h10
`define REG_TIME    8'h14
`define REG_SOUND   8'h18
`define REG_PAYLOAD 8'h1C
`define REG_STATUS  8'h20

// ****************************************
// field positions
// ****************************************
`define CTRL_LONG_BIT  3
`define CMD_START_BIT  0
`define CMD_FLUSH_BIT  1
`define CMD_CLEAR_BIT  2

// ****************************************
// reset values
// ****************************************
`define RST_FAMILY  8'h5A   // family code after reset; value arbitrary
`define RST_OFFSET  8'h12
`define RST_SOUND   16'h3A98
`define RST_SEED    16'h0000

`endif

// *** include/record_framer_pkg.sv ***
/*
 * types of the binary record framer: states and the state records.
 * assumes the defines header is compiled alongside.
 */
package record_framer_pkg;

   // framer sequence
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_PREP_REC = 3'b001,
      ST_PREP_HDR = 3'b010,
      ST_SEND_HDR = 3'b011,
      ST_SEND_REC = 3'b100
   } frame_state_e;

   // whole state of the framer except the payload store and the checksum engines
   typedef struct packed {
      frame_state_e state;
      logic [15:0]  idx;
      logic [2:0]   typeSel;
      logic         longReq;
      logic [7:0]   family;
      logic [7:0]   offset;
      logic [31:0]  serial;
      logic [7:0]   year;
      logic [7:0]   month;
      logic [7:0]   day;
      logic [7:0]   hour;
      logic [7:0]   minute;
      logic [7:0]   second;
      logic [15:0]  hundredUs;
      logic [15:0]  sound;
      logic [15:0]  count;
      logic         longHdr;
      logic [31:0]  recLen;
      logic         done;
      logic         overflow;
      logic [7:0]   txData;
      logic         txValid;
      logic [31:0]  rdData;
   } frame_s;

   // checksum accumulator state
   typedef struct packed {
      logic [15:0] sum;
      logic        odd;
   } csum_s;

endpackage : record_framer_pkg

// *** hw/record_checksum16.sv ***
/*
 * 16-bit checksum: sum of little-endian byte pairs, seeded.
 * assumes bytes arrive one per enabled cycle, in ascending order.
 */
`timescale 1ns/100ps
`include "record_framer_defines.svh"

module record_checksum16 #(
   parameter logic [15:0] SEED = `RST_SEED
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // byte feed
   input  wire logic        clear,
   input  wire logic        en,
   input  wire logic [7:0]  din,
   // result
   output logic [15:0]      sum
);

   record_framer_pkg::csum_s cs_reg;   // current state
   record_framer_pkg::csum_s cs_next;  // next state

   // ****************************************
   // accumulate
   // ****************************************
   // even bytes land low, odd bytes high; a lone last byte stays low
   always_comb begin
      cs_next = cs_reg;
      if (clear) begin
         cs_next.sum = SEED;
         cs_next.odd = 1'b0;
      end else if (en) begin
         cs_next.sum = cs_reg.odd ? cs_reg.sum + {din, 8'h00}
                                  : cs_reg.sum + {8'h00, din};
         cs_next.odd = ~cs_reg.odd;
      end
   end

   // register the state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_reg <= '{sum: 16'h0000, odd: 1'b0};
      end else begin
         cs_reg <= cs_next;
      end
   end

   assign sum = cs_reg.sum;

endmodule : record_checksum16

// *** hw/record_framer.sv ***
/*
 * binary record framer: builds a header, a common data section and a
 * buffered payload tail, and sends them as one byte stream.
 * assumes a register master on the same clock and a byte sink whose
 * ready comes from logic on the same clock.
 */
// The implementer's own choices: the register offsets and the strobed register port.
// What this block does
// - sync byte A5 at header position 0
// - header length 10, or 12 if long
// - header byte 2 is the record type code
// - header byte 3 is the family code
// - size field 16 or 32 bits by length
// - payload checksum after the size field
// - header checksum last, over preceding header bytes
// - common byte 0 is format version
// - common byte 1 is offset to data
// - common bytes 4-7 hold serial number
// - year since 1900, then month to seconds
// - month counted from zero
// - bytes 14-15 hold hundred microsecond count
// - bytes 16-17 hold speed of sound
// - positions count from zero per section
// - multi-byte fields little-endian
`timescale 1ns/100ps
`include "record_framer_defines.svh"

module record_framer #(
   parameter int DEPTH = 256   // payload tail bytes held
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdata,
   // record byte stream
   output logic [7:0]       txData,
   output logic             txValid,
   input  wire logic        txReady
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   record_framer_pkg::frame_s st_reg;   // current state
   record_framer_pkg::frame_s st_next;  // next state
   logic [7:0]  payMem [DEPTH];         // payload tail bytes
   logic [15:0] dataSum;                // payload checksum
   logic [15:0] hdrSum;                 // header checksum
   logic [7:0]  hdrByte;                // header byte at idx
   logic [7:0]  recByte;                // record byte at idx
   logic [7:0]  typeCode;               // selected record type
   logic [7:0]  hdrLen;                 // header length in use
   logic [15:0] tailPtr;                // idx within the tail
   logic        csClear;                // restart both checksums
   logic        loadSlot;               // output register free
   logic        wrPay;                  // payload append accepted

   // ****************************************
   // record type and header length
   // ****************************************
   // unknown selections fall back to the string type
   always_comb begin
      case (st_reg.typeSel)
         3'h0:    typeCode = `TYPE_AVERAGE;
         3'h1:    typeCode = `TYPE_ALTIMETER;
         3'h2:    typeCode = `TYPE_BOTTOM;
         3'h3:    typeCode = `TYPE_WATER;
         default: typeCode = `TYPE_STRING;
      endcase
   end

   assign hdrLen  = st_reg.longHdr ? `HDR_LEN_LONG : `HDR_LEN_SHORT;
   assign tailPtr = st_reg.idx - `COMMON_LEN;

   // ****************************************
   // header byte map
   // ****************************************
   always_comb begin
      logic [15:0] csPos;   // start of payload checksum
      logic [15:0] rel;     // byte within a multi-byte field
      csPos = st_reg.longHdr ? 16'h0008 : 16'h0006;
      rel   = 16'h0000;
      if (st_reg.idx == 16'h0000) begin
         hdrByte = `SYNC_BYTE;
      end else if (st_reg.idx == 16'h0001) begin
         hdrByte = hdrLen;
      end else if (st_reg.idx == 16'h0002) begin
         hdrByte = typeCode;
      end else if (st_reg.idx == 16'h0003) begin
         hdrByte = st_reg.family;
      end else if (st_reg.idx < csPos) begin
         // size, low byte first; short headers carry the low half
         rel     = st_reg.idx - `HDR_SIZE_POS;
         hdrByte = st_reg.recLen[rel[1:0]*8 +: 8];
      end else if (st_reg.idx < csPos + 16'h0002) begin
         rel     = st_reg.idx - csPos;
         hdrByte = rel[0] ? dataSum[15:8] : dataSum[7:0];
      end else begin
         // only the header checksum remains
         rel     = st_reg.idx - csPos - 16'h0002;
         hdrByte = rel[0] ? hdrSum[15:8] : hdrSum[7:0];
      end
   end

   // ****************************************
   // record byte map
   // ****************************************
   // common section first, positions counted from its start
   always_comb begin
      case (st_reg.idx)
         16'h0000: recByte = (typeCode == `TYPE_BOTTOM)
                             ? `VER_BOTTOM : `VER_PROFILE;
         16'h0001: recByte = st_reg.offset;
         16'h0004: recByte = st_reg.serial[7:0];
         16'h0005: recByte = st_reg.serial[15:8];
         16'h0006: recByte = st_reg.serial[23:16];
         16'h0007: recByte = st_reg.serial[31:24];
         16'h0008: recByte = st_reg.year;
         16'h0009: recByte = st_reg.month;
         16'h000A: recByte = st_reg.day;
         16'h000B: recByte = st_reg.hour;
         16'h000C: recByte = st_reg.minute;
         16'h000D: recByte = st_reg.second;
         16'h000E: recByte = st_reg.hundredUs[7:0];
         16'h000F: recByte = st_reg.hundredUs[15:8];
         16'h0010: recByte = st_reg.sound[7:0];
         16'h0011: recByte = st_reg.sound[15:8];
         16'h0002,
         16'h0003: recByte = 8'h00;
         default:  recByte = payMem[tailPtr[AW-1:0]];
      endcase
   end

   // ****************************************
   // checksum engines
   // ****************************************
   // both totals are built before the first byte leaves, because the
   // header must carry them; that costs one pass over the record
   record_checksum16 #(.SEED(`RST_SEED)) dataCs (
      .clk   (clk),
      .rst_n (rst_n),
      .clear (csClear),
      .en    (st_reg.state == record_framer_pkg::ST_PREP_REC),
      .din   (recByte),
      .sum   (dataSum)
   );

   record_checksum16 #(.SEED(`RST_SEED)) hdrCs (
      .clk   (clk),
      .rst_n (rst_n),
      .clear (csClear),
      .en    (st_reg.state == record_framer_pkg::ST_PREP_HDR),
      .din   (hdrByte),
      .sum   (hdrSum)
   );

   // ****************************************
   // next state
   // ****************************************
   assign loadSlot = !st_reg.txValid || txReady;
   assign wrPay    = regWr && (regAddr == `REG_PAYLOAD)
                     && (st_reg.state == record_framer_pkg::ST_IDLE)
                     && !st_reg.txValid;

   always_comb begin
      logic busy;       // a frame is still in flight
      logic lastOut;    // final byte taken by the sink
      st_next = st_reg;
      csClear = 1'b0;
      busy    = (st_reg.state != record_framer_pkg::ST_IDLE) || st_reg.txValid;
      lastOut = (st_reg.state == record_framer_pkg::ST_IDLE)
                && st_reg.txValid && txReady;

      // register writes; configuration is ignored while busy
      if (regWr && !busy) begin
         case (regAddr)
            `REG_CTRL: begin
               st_next.typeSel = regWdata[2:0];
               st_next.longReq = regWdata[`CTRL_LONG_BIT];
            end
            `REG_FAMILY: st_next.family = regWdata[7:0];
            `REG_SERIAL: st_next.serial = regWdata;
            `REG_DATE: begin
               st_next.year  = regWdata[7:0];
               st_next.month = regWdata[15:8];
               st_next.day   = regWdata[23:16];
               st_next.hour  = regWdata[31:24];
            end
            `REG_TIME: begin
               st_next.minute    = regWdata[7:0];
               st_next.second    = regWdata[15:8];
               st_next.hundredUs = regWdata[31:16];
            end
            `REG_SOUND: begin
               st_next.sound  = regWdata[15:0];
               st_next.offset = regWdata[23:16];
            end
            default: ;
         endcase
      end

      // payload append; a full buffer flags and drops the byte
      if (wrPay) begin
         if (st_reg.count == 16'(DEPTH)) begin
            st_next.overflow = 1'b1;
         end else begin
            st_next.count = st_reg.count + 16'h0001;
         end
      end

      // command strobes
      if (regWr && (regAddr == `REG_CMD)) begin
         if (regWdata[`CMD_CLEAR_BIT]) begin
            st_next.done     = 1'b0;
            st_next.overflow = 1'b0;
         end
         if (regWdata[`CMD_FLUSH_BIT] && !busy) begin
            st_next.count = 16'h0000;
         end
         if (regWdata[`CMD_START_BIT] && !busy) begin
            st_next.state   = record_framer_pkg::ST_PREP_REC;
            st_next.idx     = 16'h0000;
            st_next.recLen  = 32'(`COMMON_LEN) + 32'(st_reg.count);
            st_next.longHdr = st_reg.longReq;
            csClear         = 1'b1;
         end
      end

      // frame sequence
      case (st_reg.state)
         record_framer_pkg::ST_IDLE: begin
            if (lastOut) begin
               st_next.txValid = 1'b0;
            end
         end
         // sum the whole record so the header can carry it
         record_framer_pkg::ST_PREP_REC: begin
            if (32'(st_reg.idx) == st_reg.recLen - 32'h1) begin
               st_next.state = record_framer_pkg::ST_PREP_HDR;
               st_next.idx   = 16'h0000;
            end else begin
               st_next.idx = st_reg.idx + 16'h0001;
            end
         end
         // sum every header byte before the header checksum
         record_framer_pkg::ST_PREP_HDR: begin
            if (st_reg.idx == 16'(hdrLen) - 16'h0003) begin
               st_next.state = record_framer_pkg::ST_SEND_HDR;
               st_next.idx   = 16'h0000;
            end else begin
               st_next.idx = st_reg.idx + 16'h0001;
            end
         end
         // header in ascending order, then straight into the record
         record_framer_pkg::ST_SEND_HDR: begin
            if (loadSlot) begin
               st_next.txData  = hdrByte;
               st_next.txValid = 1'b1;
               if (st_reg.idx == 16'(hdrLen) - 16'h0001) begin
                  st_next.state = record_framer_pkg::ST_SEND_REC;
                  st_next.idx   = 16'h0000;
               end else begin
                  st_next.idx = st_reg.idx + 16'h0001;
               end
            end
         end
         record_framer_pkg::ST_SEND_REC: begin
            if (loadSlot) begin
               st_next.txData  = recByte;
               st_next.txValid = 1'b1;
               if (32'(st_reg.idx) == st_reg.recLen - 32'h1) begin
                  st_next.state = record_framer_pkg::ST_IDLE;
               end else begin
                  st_next.idx = st_reg.idx + 16'h0001;
               end
            end
         end
         default: st_next.state = record_framer_pkg::ST_IDLE;
      endcase

      // completion wins over a clear in the same cycle
      if (lastOut) begin
         st_next.done = 1'b1;
      end

      // read data, valid in the cycle after the strobe only
      st_next.rdData = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            `REG_CTRL:   st_next.rdData = {28'h0, st_reg.longReq, st_reg.typeSel};
            `REG_FAMILY: st_next.rdData = {24'h0, st_reg.family};
            `REG_SERIAL: st_next.rdData = st_reg.serial;
            `REG_DATE:   st_next.rdData = {st_reg.hour, st_reg.day,
                                           st_reg.month, st_reg.year};
            `REG_TIME:   st_next.rdData = {st_reg.hundredUs, st_reg.second,
                                           st_reg.minute};
            `REG_SOUND:  st_next.rdData = {8'h0, st_reg.offset, st_reg.sound};
            `REG_STATUS: st_next.rdData = {st_reg.count, 13'h0, st_reg.overflow,
                                           st_reg.done, busy};
            default:     st_next.rdData = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg        <= '0;
         st_reg.state  <= record_framer_pkg::ST_IDLE;
         st_reg.family <= `RST_FAMILY;
         st_reg.offset <= `RST_OFFSET;
         st_reg.sound  <= `RST_SOUND;
      end else begin
         st_reg <= st_next;
      end
   end

   // payload store; no reset, contents count only below count
   always_ff @(posedge clk) begin
      if (wrPay && (st_reg.count != 16'(DEPTH))) begin
         payMem[st_reg.count[AW-1:0]] <= regWdata[7:0];
      end
   end

   assign regRdata = st_reg.rdData;
   assign txData   = st_reg.txData;
   assign txValid  = st_reg.txValid;

endmodule : record_framer

// *** verif/record_framer_properties.sv ***
/*
 * stream content, handshake and status checks of the record framer, seen from its ports only.
 * assumes one clock domain and a register master that never writes
 * configuration while the framer is busy.
 */
`timescale 1ns/100ps
`include "record_framer_defines.svh"

module record_framer_properties #(
   parameter int DEPTH = 256   // tail depth of the framer watched
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   input  wire logic [31:0] regRdata,
   // record stream
   input  wire logic [7:0]  txData,
   input  wire logic        txValid,
   input  wire logic        txReady
);
   // ****************************************
   // helper state
   // ****************************************
   logic [15:0] pos;      // bytes accepted in this frame
   logic [15:0] hdrLen;   // header length seen at byte 1
   logic [7:0]  offset;   // offset last written
   logic [31:0] serial;   // serial last written

   // track position; a drop of valid marks the end of a frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos <= 16'h0000;
         hdrLen <= 16'h0000;
         offset <= `RST_OFFSET;
         serial <= 32'h00000000;
      end else begin
         pos <= !txValid ? 16'h0000 : (txReady ? pos + 16'h0001 : pos);
         if (txValid && txReady && pos == 16'h0001) begin
            hdrLen <= {8'h00, txData};
         end
         if (regWr && regAddr == `REG_SOUND) begin
            offset <= regWdata[23:16];
         end
         if (regWr && regAddr == `REG_SERIAL) begin
            serial <= regWdata;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ****************************************
   // sequences
   // ****************************************
   sequence s_taken;
      txValid && txReady;
   endsequence
   sequence s_hdr_taken;
      s_taken ##0 (pos < 16'h0009);
   endsequence
   sequence s_rec(int k);
      txValid && hdrLen != 16'h0000 && pos == hdrLen + 16'(k);
   endsequence

   // ****************************************
   // assertions
   // ****************************************
   a_sync_first: assert property ($rose(txValid) |-> txData == `SYNC_BYTE)
      else $error("frame did not open with the sync byte");
   a_len_code: assert property (txValid && pos == 16'h0001 |-> txData inside {8'h0A, 8'h0C})
      else $error("header length byte out of range");
   a_type_code: assert property (txValid && pos == 16'h0002 |->
      txData inside {8'h16, 8'h21, 8'h1B, 8'h1D, 8'hA0})
      else $error("record type code unknown");
   a_hdr_gapless: assert property (s_hdr_taken |=> txValid)
      else $error("gap inside header");
   a_hold_byte: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("byte changed before acceptance");
   a_version_byte: assert property (s_rec(0) |-> txData inside {8'h03, 8'h14})
      else $error("format version byte wrong");
   a_offset_byte: assert property (s_rec(1) |-> txData == offset)
      else $error("data offset byte wrong");
   a_serial_low: assert property (s_rec(4) |-> txData == serial[7:0])
      else $error("serial low byte wrong");
   a_count_bound: assert property (regRd && regAddr == `REG_STATUS |=>
      regRdata[31:16] <= 16'(DEPTH))
      else $error("tail count above depth");
endmodule : record_framer_properties

// *** verif/host_receiver.sv ***
/*
 * host side model: accepts record bytes and keeps them for the bench.
 * assumes the bench empties the byte queue between frames.
 */
`timescale 1ns/100ps

module host_receiver (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // record stream
   input  wire logic [7:0] txData,
   input  wire logic       txValid,
   output logic            txReady,
   // pacing
   input  wire logic       slow
);
   logic [7:0]  got[$];   // bytes of the current block
   logic [31:0] pace;     // stall pattern, so slow mode is irregular

   // accept bytes; ready changes only just after an edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txReady <= 1'b0;
         pace <= 32'h1357ACE1;
      end else begin
         if (txValid && txReady) begin
            got.push_back(txData);
         end
         pace <= {pace[30:0], pace[31] ^ pace[21] ^ pace[1] ^ pace[0]};
         txReady <= slow ? pace[3] : 1'b1;
      end
   end
endmodule : host_receiver

// *** verif/tb.sv ***
/*
 * self-checking bench of the record framer: register tasks, frames of
 * every record type, short and long headers, a full tail.
 * assumes the framer is idle whenever configuration is written.
 */
`timescale 1ns/100ps
`include "record_framer_defines.svh"

module tb;
   localparam int DEPTH = 8;   // small tail so overflow is reachable
   logic        clk, rst_n, regWr, regRd, txReady, slow, txValid;
   logic [7:0]  regAddr, txData;
   logic [31:0] regWdata, regRdata, seed, rdv;
   int          err_total = 0, comparisons = 0, cyc = 0;
   logic [7:0]  ra[6] = '{8'h00, 8'h08, 8'h0C, 8'h18, 8'h20, 8'h40};
   logic [31:0] rv[6] = '{32'h0, 32'h5A, 32'h0, 32'h00123A98, 32'h0, 32'h0};

   record_framer #(.DEPTH(DEPTH)) uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .txData(txData), .txValid(txValid), .txReady(txReady));
   host_receiver rx (.clk(clk), .rst_n(rst_n), .txData(txData), .txValid(txValid),
      .txReady(txReady), .slow(slow));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : nxt
   // sum of little-endian byte pairs, lone last byte low
   function automatic logic [15:0] csum(input logic [7:0] q[$]);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < q.size(); i++) s += (i % 2) ? {q[i], 8'h00} : {8'h00, q[i]};
      return s;
   endfunction : csum
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      rdv = regRdata;
   endtask : rd
   task automatic final_report;
      $display("totals: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   // ****************************************
   // one frame: configure, fill tail, start, compare stream
   // ****************************************
   task automatic run_frame(input logic [2:0] t, input int n);
      logic [7:0]  h[$], rc[$], b;
      logic [31:0] ser, dat, tim, snd, fam, cnt;
      logic [15:0] ds;
      int          k;
      ser = nxt();
      dat = nxt();
      tim = nxt();
      fam = nxt();
      // data offset points just past the common section, so the host can find the tail
      snd = (nxt() & 32'h0000FFFF) | 32'h00120000;
      cnt = (n > DEPTH) ? DEPTH : n;
      wr(`REG_CMD, 32'h00000006);   // flush tail, clear sticky flags
      wr(`REG_CTRL, {28'h0, t[0], t});
      wr(`REG_FAMILY, fam);
      wr(`REG_SERIAL, ser);
      wr(`REG_DATE, dat);
      wr(`REG_TIME, tim);
      wr(`REG_SOUND, snd);
      rc = {(t == 3'd2) ? 8'h14 : 8'h03, snd[23:16], 8'h00, 8'h00, ser[7:0], ser[15:8],
            ser[23:16], ser[31:24], dat[7:0], dat[15:8], dat[23:16], dat[31:24],
            tim[7:0], tim[15:8], tim[23:16], tim[31:24], snd[7:0], snd[15:8]};
      for (k = 0; k < n; k++) begin
         b = nxt();
         wr(`REG_PAYLOAD, {24'h0, b});
         if (k < DEPTH) rc.push_back(b);
      end
      rd(`REG_STATUS);
      chk(rdv, {cnt[15:0], 13'h0, n > DEPTH, 2'b00});
      ds = csum(rc);
      h = {`SYNC_BYTE, t[0] ? 8'h0C : 8'h0A,
           (t == 0) ? 8'h16 : (t == 1) ? 8'h21 : (t == 2) ? 8'h1B : (t == 3) ? 8'h1D : 8'hA0,
           fam[7:0], 8'(rc.size()), 8'(rc.size() >> 8)};
      if (t[0]) h = {h, 8'h00, 8'h00};
      h = {h, ds[7:0], ds[15:8]};
      ds = csum(h);
      h = {h, ds[7:0], ds[15:8], rc};
      wr(`REG_CMD, 32'h00000001);
      k = 0;
      do begin
         rd(`REG_STATUS);
         k++;
      end while (rdv[1] !== 1'b1 && k < 300);
      chk(rdv, {cnt[15:0], 13'h0, n > DEPTH, 2'b10});
      chk(rx.got.size(), h.size());
      for (k = 0; k < h.size() && k < rx.got.size(); k++) begin
         chk(rx.got[k], h[k]);
      end
      // host view: locate the tail through the offset, then validate the header alone
      if (rx.got.size() == h.size()) begin
         k = rx.got[1];
         b = rx.got[k + 1];
         if (cnt != 0) chk(rx.got[k + b], rc[18]);
         ds = csum(rx.got[0:k-3]);
         chk({rx.got[k-1], rx.got[k-2]}, ds);
      end
      rx.got.delete();
      $display("frame test type %0d tail %0d finished", t, n);
   endtask : run_frame

   // ****************************************
   // clock, timeout, main sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // a hang is cut short well past the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      slow = 1'b0;
      seed = 32'hE44A45C3;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk(rdv, rv[i]);
      end
      $display("register reset test finished");
      for (int t = 0; t < 6; t++) begin
         slow <= t[1];
         run_frame(3'(t), (t == 0) ? DEPTH + 1 : (t == 1) ? 0 : int'(nxt() % 5));
      end
      final_report();
   end
endmodule : tb

bind record_framer record_framer_properties #(.DEPTH(DEPTH)) props (.clk(clk),
   .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .txData(txData), .txValid(txValid), .txReady(txReady));
